//--- src/adc_ctl_defines.svh
// Register offsets, field positions, reset values and timing counts for the converter control block
`ifndef ADC_CTL_DEFINES_SVH
`define ADC_CTL_DEFINES_SVH
`define OFS_CONTROL 8'h00
`define OFS_TRIGGER 8'h04
`define OFS_FLAGS 8'h08
`define OFS_IRQ_EN 8'h0C
`define OFS_DMA_EN 8'h10
`define OFS_RESULT 8'h14
`define CTL_CUR_HI 14
`define CTL_CUR_LO 12
`define CTL_BUSY 10
`define CTL_RUN 1
`define CTL_ENABLE 0
`define TRG_LAST_HI 13
`define TRG_LAST_LO 11
`define TRG_FIRST_HI 10
`define TRG_FIRST_LO 8
`define TRG_ALIGN 7
`define TRG_MODE 6
`define TRG_SRC_HI 5
`define TRG_SRC_LO 4
`define TRG_SMP_HI 2
`define TRG_SMP_LO 0
`define FLG_OVF 8
`define TRG_RESET 16'h0007
`define TRG_MASK 16'h3FF7
`define SMP_BASE 4'h4
`define CONV_TICKS 4'hC
`define CONV_DIV 8'h04
`define INPUT_MAX 3'h7
`endif

//--- src/adc_ctl_pkg.sv
// Types shared by the converter control block
package adc_ctl_pkg;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SAMPLE = 2'b01, ST_CONVERT = 2'b10} conv_state_t;
    typedef enum logic [1:0] {SRC_SOFT = 2'b00, SRC_TIMER = 2'b01, SRC_RSVD = 2'b10, SRC_PIN = 2'b11} trig_src_t;
endpackage

//--- src/adc_sequence_irq_dma_control.sv
// Converter sequencing, flags, interrupt and DMA request control behind an APB slave
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "adc_ctl_defines.svh"

module adc_sequence_irq_dma_control
    import adc_ctl_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [11:0] conv_data,
    input wire logic timer_underflow,
    input wire logic external_trigger_pin,
    output logic converter_clock_enable,
    output logic sample_enable,
    output logic [2:0] conv_input,
    output logic irq,
    output logic [15:0] dma_req,
    input wire logic [15:0] dma_ack
);

    // Realign a raw result; used by the read path and by a check
    function automatic logic [15:0] align_result(input logic [11:0] raw, input logic left);
        align_result = left ? {raw, 4'h0} : {4'h0, raw};
    endfunction

    // ============================================================
    // Register state
    logic run_bit_reg, run_bit_next;
    logic module_enable_reg, module_enable_next;
    logic [15:0] trg_reg, trg_next;
    logic [8:0] flag_reg, flag_next;
    logic [8:0] irq_en_reg, irq_en_next;
    logic [15:0] dma_en_reg, dma_en_next;
    logic [11:0] raw_result_reg, raw_result_next;
    logic [2:0] result_input_reg, result_input_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;
    logic [15:0] dma_req_reg, dma_req_next;

    // Sequencer state
    conv_state_t state_reg, state_next;
    logic [3:0] tick_cnt_reg, tick_cnt_next;
    logic [2:0] cur_input_reg, cur_input_next;
    logic pending_reg, pending_next;
    logic soft_armed_reg, soft_armed_next;
    logic [7:0] div_cnt_reg, div_cnt_next;
    logic conv_tick_reg, conv_tick_next;

    // Pin synchroniser and edge detect
    logic pin_meta_reg, pin_sync_reg, pin_prev_reg;

    logic wr_en, rd_setup, addr_ok;
    logic load, busy, last_hit, stop_now, trigger;
    logic [2:0] first_in, last_in;
    logic [7:0] done_set;
    logic [8:0] flag_clr;

    assign first_in = trg_reg[`TRG_FIRST_HI:`TRG_FIRST_LO];
    assign last_in = trg_reg[`TRG_LAST_HI:`TRG_LAST_LO];
    assign busy = pending_reg | (state_reg != ST_IDLE);
    assign wr_en = psel & penable & pwrite & pready_reg;
    assign rd_setup = psel & ~penable;
    assign addr_ok = (paddr == `OFS_CONTROL) | (paddr == `OFS_TRIGGER) | (paddr == `OFS_FLAGS) |
                     (paddr == `OFS_IRQ_EN) | (paddr == `OFS_DMA_EN) | (paddr == `OFS_RESULT);
    assign load = conv_tick_reg & (state_reg == ST_CONVERT) & (tick_cnt_reg == 4'h1);
    assign last_hit = cur_input_reg == last_in;

    // ============================================================
    // Two-flop pin synchroniser plus edge-detect flop; the second and third stages feed logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
            pin_prev_reg <= 1'b1;
        end
        else
        begin
            pin_meta_reg <= external_trigger_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // ============================================================
    // Trigger selection, ignored while busy or disarmed
    always_comb
    begin
        unique case (trig_src_t'(trg_reg[`TRG_SRC_HI:`TRG_SRC_LO]))
            SRC_SOFT: trigger = soft_armed_reg;
            SRC_TIMER: trigger = run_bit_reg & timer_underflow;
            SRC_RSVD: trigger = 1'b0;
            SRC_PIN: trigger = run_bit_reg & pin_prev_reg & ~pin_sync_reg;
        endcase
        trigger = trigger & module_enable_reg & ~busy;
    end

    // ============================================================
    // Sequencer next state; converter tick only runs while enabled
    always_comb
    begin
        state_next = state_reg;
        tick_cnt_next = tick_cnt_reg;
        cur_input_next = cur_input_reg;
        pending_next = pending_reg | trigger;
        soft_armed_next = soft_armed_reg;
        stop_now = 1'b0;
        div_cnt_next = div_cnt_reg;
        conv_tick_next = 1'b0;
        if (module_enable_reg)
        begin
            div_cnt_next = (div_cnt_reg == `CONV_DIV - 8'h01) ? 8'h00 : div_cnt_reg + 8'h01;
            conv_tick_next = div_cnt_reg == `CONV_DIV - 8'h01;
        end
        else
        begin
            div_cnt_next = 8'h00;
        end
        // A 0 write rearms; only a fresh 1 write starts a soft run
        if (wr_en && paddr == `OFS_CONTROL)
        begin
            soft_armed_next = pwdata[`CTL_RUN] & ~run_bit_reg;
        end
        else if (trigger)
        begin
            soft_armed_next = 1'b0;
        end
        unique case (state_reg)
            ST_IDLE:
            begin
                if (pending_reg && conv_tick_reg)
                begin
                    pending_next = 1'b0;
                    state_next = ST_SAMPLE;
                    cur_input_next = first_in;
                    tick_cnt_next = trg_reg[`TRG_SMP_HI:`TRG_SMP_LO] + `SMP_BASE;
                end
            end
            ST_SAMPLE:
            begin
                if (conv_tick_reg)
                begin
                    tick_cnt_next = tick_cnt_reg - 4'h1;
                    if (tick_cnt_reg == 4'h1)
                    begin
                        state_next = ST_CONVERT;
                        tick_cnt_next = `CONV_TICKS;
                    end
                end
            end
            ST_CONVERT:
            begin
                if (conv_tick_reg)
                begin
                    tick_cnt_next = tick_cnt_reg - 4'h1;
                end
                if (load)
                begin
                    // Overwrite errors do not enter this decision
                    stop_now = ~run_bit_reg | (last_hit & ~trg_reg[`TRG_MODE]);
                    if (stop_now)
                    begin
                        state_next = ST_IDLE;
                        cur_input_next = (cur_input_reg == `INPUT_MAX) ? 3'h0 : cur_input_reg;
                    end
                    else
                    begin
                        state_next = ST_SAMPLE;
                        cur_input_next = last_hit ? first_in : cur_input_reg + 3'h1;
                        tick_cnt_next = trg_reg[`TRG_SMP_HI:`TRG_SMP_LO] + `SMP_BASE;
                    end
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        // Clearing enable abandons the sequence at once
        if (!module_enable_reg)
        begin
            state_next = ST_IDLE;
            pending_next = 1'b0;
        end
    end

    // ============================================================
    // Flags, result store, interrupt and DMA requests
    always_comb
    begin
        done_set = load ? 8'h01 << cur_input_reg : 8'h00;
        flag_clr = (wr_en && paddr == `OFS_FLAGS) ? pwdata[8:0] : 9'h000;
        // Accepted DMA transfer consumes the latest input's flag
        if (|(dma_ack & dma_req_reg))
        begin
            flag_clr[result_input_reg] = 1'b1;
        end
        // Set wins over a clear in the same cycle
        flag_next = (flag_reg & ~flag_clr) | {1'b0, done_set};
        if (load && flag_reg[cur_input_reg])
        begin
            flag_next[`FLG_OVF] = 1'b1;
        end
        raw_result_next = load ? conv_data : raw_result_reg;
        result_input_next = load ? cur_input_reg : result_input_reg;
        irq_next = |(flag_reg & irq_en_reg);
        dma_req_next = (|flag_reg[7:0]) ? dma_en_reg : 16'h0000;
    end

    // ============================================================
    // APB slave: one wait-free access phase, error on unmapped words
    always_comb
    begin
        run_bit_next = run_bit_reg;
        module_enable_next = module_enable_reg;
        trg_next = trg_reg;
        irq_en_next = irq_en_reg;
        dma_en_next = dma_en_reg;
        prdata_next = prdata_reg;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        if (rd_setup)
        begin
            pready_next = 1'b1;
            pslverr_next = ~addr_ok;
            unique case (paddr)
                `OFS_CONTROL: prdata_next = {17'h00000, cur_input_reg, 1'b0, busy, 8'h00, run_bit_reg,
                    module_enable_reg};
                `OFS_TRIGGER: prdata_next = {16'h0000, trg_reg};
                `OFS_FLAGS: prdata_next = {23'h000000, flag_reg};
                `OFS_IRQ_EN: prdata_next = {23'h000000, irq_en_reg};
                `OFS_DMA_EN: prdata_next = {16'h0000, dma_en_reg};
                `OFS_RESULT: prdata_next = {16'h0000, align_result(raw_result_reg, trg_reg[`TRG_ALIGN])};
                default: prdata_next = 32'h00000000;
            endcase
        end
        if (wr_en)
        begin
            unique case (paddr)
                `OFS_CONTROL:
                begin
                    run_bit_next = pwdata[`CTL_RUN];
                    module_enable_next = pwdata[`CTL_ENABLE];
                end
                `OFS_TRIGGER: trg_next = pwdata[15:0] & `TRG_MASK;
                `OFS_IRQ_EN: irq_en_next = pwdata[8:0];
                `OFS_DMA_EN: dma_en_next = pwdata[15:0];
                default: trg_next = trg_reg;
            endcase
        end
    end

    // ============================================================
    // All registers except the pin synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_bit_reg <= 1'b0;
            module_enable_reg <= 1'b0;
            trg_reg <= `TRG_RESET;
            flag_reg <= 9'h000;
            irq_en_reg <= 9'h000;
            dma_en_reg <= 16'h0000;
            raw_result_reg <= 12'h000;
            result_input_reg <= 3'h0;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            dma_req_reg <= 16'h0000;
            state_reg <= ST_IDLE;
            tick_cnt_reg <= 4'h0;
            cur_input_reg <= 3'h0;
            pending_reg <= 1'b0;
            soft_armed_reg <= 1'b0;
            div_cnt_reg <= 8'h00;
            conv_tick_reg <= 1'b0;
        end
        else
        begin
            run_bit_reg <= run_bit_next;
            module_enable_reg <= module_enable_next;
            trg_reg <= trg_next;
            flag_reg <= flag_next;
            irq_en_reg <= irq_en_next;
            dma_en_reg <= dma_en_next;
            raw_result_reg <= raw_result_next;
            result_input_reg <= result_input_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            dma_req_reg <= dma_req_next;
            state_reg <= state_next;
            tick_cnt_reg <= tick_cnt_next;
            cur_input_reg <= cur_input_next;
            pending_reg <= pending_next;
            soft_armed_reg <= soft_armed_next;
            div_cnt_reg <= div_cnt_next;
            conv_tick_reg <= conv_tick_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign dma_req = dma_req_reg;
    assign converter_clock_enable = module_enable_reg;
    assign sample_enable = state_reg[0]; // Only the sampling code has bit 0 set
    assign conv_input = cur_input_reg;

    // ============================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    done_flag_set_a: assert property (load |=> flag_reg[$past(cur_input_reg)])
        else $error("done flag not set on load");
    ovf_flag_set_a: assert property (load && flag_reg[cur_input_reg] |=> flag_reg[`FLG_OVF])
        else $error("overwrite flag not set");
    flag_clear_a: assert property (wr_en && paddr == `OFS_FLAGS && pwdata[`FLG_OVF] && !load
        |=> !flag_reg[`FLG_OVF])
        else $error("overwrite flag not cleared");
    ovf_continue_a: assert property (load && flag_reg[cur_input_reg] && run_bit_reg && !last_hit
        |=> state_reg == ST_SAMPLE)
        else $error("sequence halted on overwrite");
    irq_gate_a: assert property (irq == $past(|(flag_reg & irq_en_reg)))
        else $error("interrupt gating wrong");
    dma_gate_a: assert property (dma_en_reg[0] && |flag_reg[7:0] ##1 dma_en_reg[0] |-> dma_req[0])
        else $error("dma request missing");
    top_input_wrap_a: assert property (load && stop_now && cur_input_reg == `INPUT_MAX |=> conv_input == 3'h0)
        else $error("current input not zero after top stop");
    busy_idle_a: assert property (state_reg == ST_SAMPLE |-> busy)
        else $error("busy low while sampling");
    run_hold_a: assert property (!(wr_en && paddr == `OFS_CONTROL) |=> $stable(run_bit_reg))
        else $error("run bit changed by itself");
    enable_stop_a: assert property (!module_enable_reg |=> state_reg == ST_IDLE && !conv_tick_reg)
        else $error("converter active while disabled");
    align_read_a: assert property (rd_setup && paddr == `OFS_RESULT |=>
        prdata[15:0] == align_result($past(raw_result_reg), $past(trg_reg[`TRG_ALIGN])))
        else $error("result alignment wrong");
    busy_ignore_a: assert property (busy && !(state_reg == ST_IDLE && conv_tick_reg) |=> $stable(cur_input_reg) ||
        state_reg != ST_IDLE || $past(state_reg) != ST_IDLE)
        else $error("trigger accepted while busy");

endmodule

//--- verif/conv_dma_model.sv
// Converter core and DMA controller model facing the control block
`timescale 1ns/1ps
module conv_dma_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] conv_input,
    input wire logic sample_enable,
    input wire logic [15:0] dma_req,
    input wire logic [3:0] ack_delay,
    output logic [11:0] conv_data,
    output logic [15:0] dma_ack
);
    logic held;
    logic [3:0] cnt;
    // ====
    // Core result: tagged with the input; inverted while sampling so stale data never matches
    assign conv_data = sample_enable ? ~{4'hA, 5'h00, conv_input} : {4'hA, 5'h00, conv_input};
    // ====
    // One acceptance per request after ack_delay cycles; rearms only once the request drops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 4'h0;
            held <= 1'b0;
            dma_ack <= 16'h0000;
        end
        else
        begin
            dma_ack <= 16'h0000;
            if (dma_req == 16'h0000)
            begin
                held <= 1'b0;
                cnt <= 4'h0;
            end
            else if (!held && cnt >= ack_delay)
            begin
                dma_ack <= dma_req;
                held <= 1'b1;
            end
            else
                cnt <= cnt + 4'h1;
        end
    end
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_ctl_defines.svh"
module tb_top;
    logic pclk;
    logic presetn;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [11:0] conv_data;
    logic timer_underflow;
    logic external_trigger_pin;
    logic converter_clock_enable;
    logic sample_enable;
    logic [2:0] conv_input;
    logic irq;
    logic [15:0] dma_req;
    logic [15:0] dma_ack;
    logic [3:0] ack_delay;
    logic [31:0] rdat;
    logic err;
    logic saw_req;
    int fail_count;
    int tests_run;
    adc_sequence_irq_dma_control dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_data(conv_data), .timer_underflow(timer_underflow),
        .external_trigger_pin(external_trigger_pin), .converter_clock_enable(converter_clock_enable),
        .sample_enable(sample_enable), .conv_input(conv_input), .irq(irq), .dma_req(dma_req),
        .dma_ack(dma_ack));
    conv_dma_model model_u (.pclk(pclk), .presetn(presetn), .conv_input(conv_input),
        .sample_enable(sample_enable), .dma_req(dma_req), .ack_delay(ack_delay),
        .conv_data(conv_data), .dma_ack(dma_ack));
    // ====
    // Clock, 100 ns period
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Remember any DMA request on channel 0
    always @(posedge pclk)
        if (dma_req[0] === 1'b1)
            saw_req <= 1'b1;
    // ====
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1)
            fail_count++;
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Run low for over two converter ticks, then high, so each start is a fresh 0-to-1
    task automatic start(input logic [31:0] trg);
        wr(`OFS_TRIGGER, trg);
        wr(`OFS_CONTROL, 32'h1);
        repeat (10) @(posedge pclk);
        wr(`OFS_CONTROL, 32'h3);
    endtask
    // Poll busy with a bound; a hang shows up as a mismatch
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `OFS_CONTROL, 32'h0);
            n++;
        end
        while (rdat[`CTL_BUSY] !== 1'b0 && n < 300);
        chk({31'h0, rdat[`CTL_BUSY]}, 32'h0);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog far beyond the expected thousand or so cycles
    initial
    begin
        repeat (30000) @(posedge pclk);
        fail_count++;
        wrap_up();
    end
    // ====
    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        timer_underflow = 1'b0;
        external_trigger_pin = 1'b1;
        ack_delay = 4'h0;
        saw_req = 1'b0;
        fail_count = 0;
        tests_run = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped address
        rdchk(`OFS_TRIGGER, 32'h7);
        rdchk(`OFS_CONTROL, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        // One-time pass over inputs 2..3, right aligned
        wr(`OFS_IRQ_EN, 32'h4);
        start(32'h1A00);
        repeat (8) @(posedge pclk);
        rdchk(`OFS_CONTROL, 32'h2403);
        chk({31'h0, converter_clock_enable}, 32'h1);
        wait_idle();
        rdchk(`OFS_FLAGS, 32'hC);
        rdchk(`OFS_RESULT, 32'hA03);
        rdchk(`OFS_CONTROL, 32'h3003);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_TRIGGER, 32'h1A80);
        rdchk(`OFS_RESULT, 32'hA030);
        wr(`OFS_FLAGS, 32'h0);
        rdchk(`OFS_FLAGS, 32'hC);
        wr(`OFS_FLAGS, 32'h8);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_FLAGS, 32'h4);
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // Continuous on input 0, flags left set so later loads overwrite
        wr(`OFS_IRQ_EN, 32'h100);
        start(32'h0040);
        repeat (100) @(posedge pclk);
        rdchk(`OFS_RESULT, 32'hA00);
        repeat (150) @(posedge pclk);
        rdchk(`OFS_CONTROL, 32'h0403);
        rdchk(`OFS_FLAGS, 32'h101);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_CONTROL, 32'h1);
        wait_idle();
        rdchk(`OFS_CONTROL, 32'h1);
        wr(`OFS_FLAGS, 32'h1FF);
        // Stop after the highest input reads as input zero
        start(32'h3F00);
        wait_idle();
        rdchk(`OFS_CONTROL, 32'h3);
        rdchk(`OFS_RESULT, 32'hA07);
        wr(`OFS_FLAGS, 32'h1FF);
        // DMA on channel 0 with a slow acceptance; software then withdraws the enable
        wr(`OFS_IRQ_EN, 32'h0);
        wr(`OFS_DMA_EN, 32'h1);
        ack_delay <= 4'h6;
        start(32'h2D00);
        wait_idle();
        repeat (20) @(posedge pclk);
        rdchk(`OFS_FLAGS, 32'h0);
        chk({31'h0, saw_req}, 32'h1);
        wr(`OFS_DMA_EN, 32'h0);
        // Hardware sources: timer, reserved, pin
        for (int s = 1; s < 4; s++)
        begin
            start(32'h2400 | (s << 4));
            repeat (20) @(posedge pclk);
            // First pass still shows input 5 from the DMA run
            rdchk(`OFS_CONTROL, (s == 1) ? 32'h5003 : 32'h4003);
            timer_underflow <= (s != 3);
            external_trigger_pin <= (s == 1);
            @(posedge pclk);
            timer_underflow <= 1'b0;
            repeat (12) @(posedge pclk);
            external_trigger_pin <= 1'b1;
            apb(1'b0, `OFS_CONTROL, 32'h0);
            chk({31'h0, rdat[`CTL_BUSY]}, {31'h0, s != 2});
            wait_idle();
            rdchk(`OFS_FLAGS, (s != 2) ? 32'h10 : 32'h0);
            wr(`OFS_FLAGS, 32'h1FF);
        end
        // Module disable stops the converter clock
        wr(`OFS_CONTROL, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, converter_clock_enable}, 32'h0);
        rdchk(`OFS_CONTROL, 32'h4000);
        wrap_up();
    end
endmodule
